// [hdl/byte_buffer_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module byte_buffer_mem (
    input  wire logic       i_sys_clk,
    input  wire logic       i_we,
    input  wire logic [3:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_re,
    input  wire logic [3:0] i_raddr,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [0:15];
    logic [7:0] rdata_reg;

    // No reset on the array; contents are only read after being written
    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_re) begin
            rdata_reg <= mem[i_raddr];
        end
    end

    assign o_rdata = rdata_reg;
endmodule // byte_buffer_mem

`default_nettype wire

// [hdl/disc_write_map.svh]
// Overview of operation
// - Sixteen eight-bit byte buffer between channel and serializer
// - Write pointer selects slot, increments per write
// - Read pointer selects slot, increments per read
// - Output holding byte shifts out at own rate
// - Occupancy counter: down on write, up on read
// - Request buffer writes while eight or fewer bytes
// - Buffer read beats buffer write when both pending
// - Hold channel connection until twelve bytes or full
// - Take at least eight bytes before searching; fewer once the channel signals done
// - Staged bytes move singly; wide paths bring several
// - Search sector, then send preamble through shifter
// - Preamble codes preload output holding register first
// - Zero-fill sector up to 1024 data bytes
// - Checksum accumulates, loads right after last byte
// - Gap advances sector; after 1011 wrap, bump track
// - Increment via checksum register; track goes out there
// - Address kept after order ends until reload
// - Serial stream is Manchester coded
// - Sense byte one bits 1,2 mark unavailable
// - Protected track blocks write, violation reported
// - Whole sector written on first pass
`ifndef DISC_WRITE_MAP_SVH
`define DISC_WRITE_MAP_SVH

`define DW_BUF_DEPTH      5'd16
`define DW_REQ_LEVEL      5'd8
`define DW_FILL_MIN       5'd8
`define DW_CONNECT_STOP   5'd12
`define DW_SECTOR_BYTES   11'd1024
`define DW_SECTOR_LAST    4'hb
`define DW_TRACK_LAST     11'h18f
`define DW_PRE_LEN        11'd8
`define DW_PRE_BYTE       8'h55
`define DW_SYNC_BYTE      8'h5c
`define DW_SENSE_UNAV     8'h60
`define DW_CLK_NS         20
`define DW_HALF_CELL_NS   160
`define DW_HALF_CELL_CYC  (`DW_HALF_CELL_NS / `DW_CLK_NS)

`endif

// [hdl/disc_write_order_datapath.sv]
`timescale 1ns/1ps
`default_nettype none
`include "disc_write_map.svh"

module disc_write_order_datapath (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_order_start,
    input  wire logic                       i_chan_done,
    input  wire disc_write_pkg::path_width_e i_path_width,
    input  wire disc_write_pkg::chan_word_s  i_chan,
    input  wire logic                       i_seek_load,
    input  wire disc_write_pkg::disc_addr_s  i_seek_addr,
    input  wire logic [3:0]                 i_cur_sector,
    input  wire logic                       i_protect,
    output logic                            o_chan_req,
    output logic                            o_busy,
    output logic                            o_ser_data,
    output logic                            o_ser_en,
    output logic [10:0]                     o_track,
    output logic [7:0]                      o_sense_byte1,
    output logic                            o_protect_violation,
    output logic                            o_sector_done
);
    // Pin inputs: three flops, value accepted once stages two and three agree
    logic [4:0] sync1_reg, sync2_reg, sync3_reg, pin_reg, pin_next;

    always_comb begin
        pin_next = (sync2_reg == sync3_reg) ? sync3_reg : pin_reg;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            sync3_reg <= 5'h00;
            pin_reg   <= 5'h00;
        end else begin
            sync1_reg <= {i_protect, i_cur_sector};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg   <= pin_next;
        end
    end

    logic       prot;
    logic [3:0] cur_sector;
    assign prot       = pin_reg[4];
    assign cur_sector = pin_reg[3:0];

    // Half-cell enable; Manchester needs two half-cells per bit
    logic [7:0] div_reg, div_next;
    logic       half_tick;
    assign half_tick = (div_reg == 8'h00);

    always_comb begin
        div_next = half_tick ? 8'(`DW_HALF_CELL_CYC - 1) : div_reg - 8'h01;
    end

    disc_write_pkg::wr_phase_e  phase_reg, phase_next;
    disc_write_pkg::disc_addr_s addr_reg, addr_next;
    logic [14:0] p_reg, p_next;
    logic [10:0] bctr_reg, bctr_next;
    logic [7:0]  k_reg, k_next, j_reg, j_next;
    logic        k_full_reg, k_full_next, j_full_reg, j_full_next;
    logic        rd_pend_reg, rd_pend_next;
    logic [31:0] stg_reg, stg_next;
    logic [2:0]  stg_cnt_reg, stg_cnt_next;
    logic [3:0]  wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [4:0]  vac_reg, vac_next, active;
    logic        connect_reg, connect_next, req_reg, req_next;
    logic        done_reg, done_next, viol_reg, viol_next, unav_reg, unav_next;
    logic [10:0] track_reg, track_next;
    logic [7:0]  sense_reg, sense_next;
    logic        sdone_reg, sdone_next;
    logic        busy_reg, busy_next;
    logic        wr_go, rd_go, take, k_take;
    logic [7:0]  rdata;

    // Shifter state
    logic [7:0] sh_reg, sh_next;
    logic [2:0] bit_reg, bit_next;
    logic       half_reg, half_next, sh_on_reg, sh_on_next, ser_reg, ser_next;
    logic       cur_bit;

    // Occupancy counter holds free slots: write counts down, read counts up
    assign active = `DW_BUF_DEPTH - vac_reg;
    assign take   = req_reg & i_chan.valid;
    assign k_take = half_tick & k_full_reg
                    & (~sh_on_reg | (half_reg & (bit_reg == 3'd7)));
    // Read first so the serializer never starves
    assign rd_go  = (phase_reg == disc_write_pkg::PH_DATA) & ~k_full_reg & ~rd_pend_reg
                    & (vac_reg != `DW_BUF_DEPTH) & (bctr_reg < `DW_SECTOR_BYTES);
    assign wr_go  = j_full_reg & (vac_reg != 5'd0) & ~rd_go;

    byte_buffer_mem u_byte_buffer (
        .i_sys_clk (i_sys_clk),
        .i_we      (wr_go),
        .i_waddr   (wptr_reg),
        .i_wdata   (j_reg),
        .i_re      (rd_go),
        .i_raddr   (rptr_reg),
        .o_rdata   (rdata)
    );

    always_comb begin
        phase_next   = phase_reg;
        addr_next    = addr_reg;
        p_next       = p_reg;
        bctr_next    = bctr_reg;
        k_next       = k_reg;
        k_full_next  = k_full_reg & ~k_take;
        rd_pend_next = rd_go;
        j_next       = j_reg;
        j_full_next  = j_full_reg & ~wr_go;
        stg_next     = stg_reg;
        stg_cnt_next = stg_cnt_reg;
        wptr_next    = wr_go ? wptr_reg + 4'h1 : wptr_reg;
        rptr_next    = rd_go ? rptr_reg + 4'h1 : rptr_reg;
        vac_next     = vac_reg - {4'h0, wr_go} + {4'h0, rd_go};
        done_next    = done_reg | i_chan_done;
        viol_next    = viol_reg;
        unav_next    = unav_reg;
        track_next   = track_reg;
        sdone_next   = 1'b0;

        // Channel word lands highest byte first in the staging register
        if (take) begin
            unique case (i_path_width)
                disc_write_pkg::PATH_8: begin
                    stg_next     = {i_chan.data[7:0], 24'h000000};
                    stg_cnt_next = 3'd1;
                end
                disc_write_pkg::PATH_16: begin
                    stg_next     = {i_chan.data[15:0], 16'h0000};
                    stg_cnt_next = 3'd2;
                end
                disc_write_pkg::PATH_32: begin
                    stg_next     = i_chan.data;
                    stg_cnt_next = 3'd4;
                end
                default: begin
                    stg_next     = i_chan.data;
                    stg_cnt_next = 3'd4;
                end
            endcase
        end else if ((stg_cnt_reg != 3'd0) && (!j_full_reg || wr_go)) begin
            j_next       = stg_reg[31:24];
            j_full_next  = 1'b1;
            stg_next     = {stg_reg[23:0], 8'h00};
            stg_cnt_next = stg_cnt_reg - 3'd1;
        end

        // Buffer read data arrives one cycle after the read cycle
        if (rd_pend_reg) begin
            k_next      = rdata;
            k_full_next = 1'b1;
            p_next      = {p_reg[14:8], p_reg[7:0] + rdata};
        end

        unique case (phase_reg)
            disc_write_pkg::PH_IDLE: begin
                if (i_order_start) begin
                    phase_next   = disc_write_pkg::PH_FILL;
                    // A done pulse in the start cycle must not be lost
                    done_next    = i_chan_done;
                    viol_next    = 1'b0;
                    wptr_next    = 4'h0;
                    rptr_next    = 4'h0;
                    vac_next     = `DW_BUF_DEPTH;
                    j_full_next  = 1'b0;
                    stg_cnt_next = 3'd0;
                end else if (i_seek_load) begin
                    addr_next  = i_seek_addr;
                    track_next = i_seek_addr.track;
                    unav_next  = 1'b0;
                end
            end
            disc_write_pkg::PH_FILL: begin
                if ((active >= `DW_FILL_MIN) || done_reg) begin
                    phase_next = disc_write_pkg::PH_SEARCH;
                end
            end
            disc_write_pkg::PH_SEARCH: begin
                if (prot) begin
                    viol_next  = 1'b1;
                    phase_next = disc_write_pkg::PH_IDLE;
                end else if (cur_sector == addr_reg.sector) begin
                    phase_next = disc_write_pkg::PH_PREAMBLE;
                    bctr_next  = 11'd0;
                    p_next     = 15'h0000;
                end
            end
            disc_write_pkg::PH_PREAMBLE: begin
                if (!k_full_reg) begin
                    k_full_next = 1'b1;
                    if (bctr_reg == `DW_PRE_LEN - 11'd1) begin
                        k_next     = `DW_SYNC_BYTE;
                        bctr_next  = 11'd0;
                        phase_next = disc_write_pkg::PH_DATA;
                    end else begin
                        k_next    = `DW_PRE_BYTE;
                        bctr_next = bctr_reg + 11'd1;
                    end
                end
            end
            disc_write_pkg::PH_DATA: begin
                if (rd_go) begin
                    bctr_next = bctr_reg + 11'd1;
                end else if (!k_full_reg && !rd_pend_reg
                             && (bctr_reg < `DW_SECTOR_BYTES)) begin
                    k_next      = 8'h00;
                    k_full_next = 1'b1;
                    bctr_next   = bctr_reg + 11'd1;
                end else if ((bctr_reg == `DW_SECTOR_BYTES) && !rd_pend_reg) begin
                    phase_next = disc_write_pkg::PH_CSUM;
                end
            end
            disc_write_pkg::PH_CSUM: begin
                if (!k_full_reg) begin
                    k_next      = p_reg[7:0];
                    k_full_next = 1'b1;
                    phase_next  = disc_write_pkg::PH_DRAIN;
                end
            end
            disc_write_pkg::PH_DRAIN: begin
                if (!k_full_reg && !sh_on_reg) begin
                    sdone_next = 1'b1;
                    phase_next = disc_write_pkg::PH_GAP_COPY;
                end
            end
            disc_write_pkg::PH_GAP_COPY: begin
                p_next     = addr_reg;
                phase_next = disc_write_pkg::PH_GAP_INC;
            end
            disc_write_pkg::PH_GAP_INC: begin
                if (p_reg[3:0] == `DW_SECTOR_LAST) begin
                    p_next = {p_reg[14:4] + 11'd1, 4'h0};
                    if (p_reg[14:4] == `DW_TRACK_LAST) begin
                        unav_next = 1'b1;
                    end
                end else begin
                    p_next = p_reg + 15'h0001;
                end
                phase_next = disc_write_pkg::PH_GAP_BACK;
            end
            disc_write_pkg::PH_GAP_BACK: begin
                addr_next  = p_reg;
                track_next = p_reg[14:4];
                if (done_reg && (stg_cnt_reg == 3'd0) && !j_full_reg
                    && (vac_reg == `DW_BUF_DEPTH)) begin
                    phase_next = disc_write_pkg::PH_IDLE;
                end else begin
                    phase_next = disc_write_pkg::PH_SEARCH;
                end
            end
            default: phase_next = disc_write_pkg::PH_IDLE;
        endcase

        // Connection opens at eight or fewer and closes at twelve or full
        if ((phase_next == disc_write_pkg::PH_IDLE) || done_next) begin
            connect_next = 1'b0;
        end else if (active <= `DW_REQ_LEVEL) begin
            connect_next = 1'b1;
        end else if ((active >= `DW_CONNECT_STOP) || (vac_reg == 5'd0)) begin
            connect_next = 1'b0;
        end else begin
            connect_next = connect_reg;
        end
        req_next   = connect_next & (stg_cnt_next == 3'd0) & ~take;
        sense_next = unav_next ? `DW_SENSE_UNAV : {addr_next.track[10:4], prot};
        busy_next  = (phase_next != disc_write_pkg::PH_IDLE);
    end

    // Shifter: MSB first, first half-cell is the complement of the bit
    always_comb begin
        sh_next    = sh_reg;
        bit_next   = bit_reg;
        half_next  = half_reg;
        sh_on_next = sh_on_reg;
        if (half_tick) begin
            if (sh_on_reg && !half_reg) begin
                half_next = 1'b1;
            end else if (sh_on_reg && (bit_reg != 3'd7)) begin
                bit_next  = bit_reg + 3'd1;
                half_next = 1'b0;
            end else begin
                sh_next    = k_full_reg ? k_reg : sh_reg;
                bit_next   = 3'd0;
                half_next  = 1'b0;
                sh_on_next = k_full_reg;
            end
        end
        cur_bit  = sh_next[3'd7 - bit_next];
        ser_next = sh_on_next & (half_next ? cur_bit : ~cur_bit);
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            div_reg     <= 8'h00;
            phase_reg   <= disc_write_pkg::PH_IDLE;
            addr_reg    <= '0;
            p_reg       <= 15'h0000;
            bctr_reg    <= 11'd0;
            k_reg       <= 8'h00;
            k_full_reg  <= 1'b0;
            rd_pend_reg <= 1'b0;
            j_reg       <= 8'h00;
            j_full_reg  <= 1'b0;
            stg_reg     <= 32'h00000000;
            stg_cnt_reg <= 3'd0;
            wptr_reg    <= 4'h0;
            rptr_reg    <= 4'h0;
            vac_reg     <= `DW_BUF_DEPTH;
            connect_reg <= 1'b0;
            req_reg     <= 1'b0;
            done_reg    <= 1'b0;
            viol_reg    <= 1'b0;
            unav_reg    <= 1'b0;
            track_reg   <= 11'h000;
            sense_reg   <= 8'h00;
            sdone_reg   <= 1'b0;
            busy_reg    <= 1'b0;
            sh_reg      <= 8'h00;
            bit_reg     <= 3'd0;
            half_reg    <= 1'b0;
            sh_on_reg   <= 1'b0;
            ser_reg     <= 1'b0;
        end else begin
            div_reg     <= div_next;
            phase_reg   <= phase_next;
            addr_reg    <= addr_next;
            p_reg       <= p_next;
            bctr_reg    <= bctr_next;
            k_reg       <= k_next;
            k_full_reg  <= k_full_next;
            rd_pend_reg <= rd_pend_next;
            j_reg       <= j_next;
            j_full_reg  <= j_full_next;
            stg_reg     <= stg_next;
            stg_cnt_reg <= stg_cnt_next;
            wptr_reg    <= wptr_next;
            rptr_reg    <= rptr_next;
            vac_reg     <= vac_next;
            connect_reg <= connect_next;
            req_reg     <= req_next;
            done_reg    <= done_next;
            viol_reg    <= viol_next;
            unav_reg    <= unav_next;
            track_reg   <= track_next;
            sense_reg   <= sense_next;
            sdone_reg   <= sdone_next;
            busy_reg    <= busy_next;
            sh_reg      <= sh_next;
            bit_reg     <= bit_next;
            half_reg    <= half_next;
            sh_on_reg   <= sh_on_next;
            ser_reg     <= ser_next;
        end
    end

    assign o_chan_req          = req_reg;
    assign o_busy              = busy_reg;
    assign o_ser_data          = ser_reg;
    assign o_ser_en            = sh_on_reg;
    assign o_track             = track_reg;
    assign o_sense_byte1       = sense_reg;
    assign o_protect_violation = viol_reg;
    assign o_sector_done       = sdone_reg;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    chk_wptr_step: assert property (wr_go |=> wptr_reg == $past(wptr_reg) + 4'h1)
        else $error("write pointer did not advance");
    chk_rptr_step: assert property (rd_go |=> rptr_reg == $past(rptr_reg) + 4'h1)
        else $error("read pointer did not advance");
    chk_occ_sign: assert property (wr_go && !rd_go
        |=> vac_reg == $past(vac_reg) - 5'd1)
        else $error("occupancy counter wrong on write");
    chk_connect_level: assert property ($rose(connect_reg) |-> $past(active) <= 5'd8)
        else $error("connection opened above eight bytes");
    chk_read_priority: assert property (rd_go && j_full_reg |=> j_full_reg)
        else $error("write taken while read pending");
    chk_zero_fill_byte: assert property (
        phase_reg == disc_write_pkg::PH_DATA && !k_full_reg
        && !rd_pend_reg && vac_reg == 5'd16 && bctr_reg < 11'd1024
        |=> k_full_reg && k_reg == 8'h00)
        else $error("zero fill byte missing");
    chk_csum_load: assert property (
        phase_reg == disc_write_pkg::PH_CSUM && !k_full_reg
        |=> k_reg == $past(p_reg[7:0]) ##1 phase_reg == disc_write_pkg::PH_DRAIN)
        else $error("checksum not loaded");
    chk_sector_wrap: assert property (
        phase_reg == disc_write_pkg::PH_GAP_INC
        && p_reg[3:0] == 4'hb |=> p_reg[3:0] == 4'h0 ##1 addr_reg.sector == 4'h0)
        else $error("sector wrap wrong");
    chk_addr_hold: assert property (
        phase_reg == disc_write_pkg::PH_IDLE && !i_seek_load
        |=> $stable(addr_reg))
        else $error("address changed while idle");
    chk_manchester: assert property ($rose(half_reg) && sh_on_reg
        |-> ser_reg != $past(ser_reg))
        else $error("no mid-bit transition");
    chk_protect_block: assert property (
        phase_reg == disc_write_pkg::PH_SEARCH && prot
        |=> phase_reg == disc_write_pkg::PH_IDLE && o_protect_violation)
        else $error("protected write not refused");

    cov_zero_fill: cover property (phase_reg == disc_write_pkg::PH_DATA && vac_reg == 5'd16
        && !k_full_reg && !rd_pend_reg);
    cov_protect: cover property ($rose(viol_reg));
    cov_wrap: cover property (phase_reg == disc_write_pkg::PH_GAP_INC && p_reg[3:0] == 4'hb);
    cov_full: cover property (vac_reg == 5'd0);
endmodule // disc_write_order_datapath

`default_nettype wire

// [hdl/disc_write_pkg.sv]
package disc_write_pkg;

    typedef enum logic [3:0] {
        PH_IDLE, PH_FILL, PH_SEARCH, PH_PREAMBLE, PH_DATA,
        PH_CSUM, PH_DRAIN, PH_GAP_COPY, PH_GAP_INC, PH_GAP_BACK
    } wr_phase_e;

    typedef enum logic [1:0] {PATH_8, PATH_16, PATH_32} path_width_e;

    typedef struct packed {
        logic [10:0] track;
        logic [3:0]  sector;
    } disc_addr_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } chan_word_s;

endpackage

// [tb/disc_write_order_datapath_test.sv]
`timescale 1ns/1ps
`default_nettype none

module disc_write_order_datapath_test;
    logic                        i_sys_clk = 1'b0;
    logic                        i_reset = 1'b1;
    logic                        i_order_start = 1'b0;
    logic                        i_chan_done;
    disc_write_pkg::path_width_e i_path_width = disc_write_pkg::PATH_32;
    disc_write_pkg::chan_word_s  i_chan;
    logic                        i_seek_load = 1'b0;
    disc_write_pkg::disc_addr_s  i_seek_addr = '0;
    logic [3:0]                  i_cur_sector = 4'h0;
    logic                        i_protect = 1'b0;
    logic                        run = 1'b0;
    logic                        o_chan_req, o_busy, o_ser_data, o_ser_en;
    logic                        o_protect_violation, o_sector_done;
    logic [10:0]                 o_track;
    logic [7:0]                  o_sense_byte1;
    int                          n_mismatch = 0;
    int                          cmp_count = 0;

    disc_write_order_datapath dut_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_order_start(i_order_start), .i_chan_done(i_chan_done), .i_path_width(i_path_width),
        .i_chan(i_chan), .i_seek_load(i_seek_load), .i_seek_addr(i_seek_addr),
        .i_cur_sector(i_cur_sector), .i_protect(i_protect), .o_chan_req(o_chan_req),
        .o_busy(o_busy), .o_ser_data(o_ser_data), .o_ser_en(o_ser_en), .o_track(o_track),
        .o_sense_byte1(o_sense_byte1), .o_protect_violation(o_protect_violation),
        .o_sector_done(o_sector_done));
    io_channel_model chan_u (.i_sys_clk(i_sys_clk), .i_run(run), .i_chan_req(o_chan_req),
        .i_path_width(i_path_width), .o_chan(i_chan), .o_done(i_chan_done));

    initial forever #10 i_sys_clk = ~i_sys_clk;

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset();
        i_reset = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        i_reset = 1'b0;
    endtask
    task automatic pulse_seek(input logic [10:0] trk, input logic [3:0] sec);
        i_seek_addr = '{track: trk, sector: sec};
        i_seek_load = 1'b1;
        @(negedge i_sys_clk);
        i_seek_load = 1'b0;
    endtask
    task automatic pulse_start();
        i_order_start = 1'b1;
        @(negedge i_sys_clk);
        i_order_start = 1'b0;
    endtask
    task automatic test_reset_sense();
        do_reset();
        chk("busy after reset", 8'h00, {7'h0, o_busy});
        chk("ser after reset", 8'h00, {6'h0, o_ser_en, o_ser_data});
        pulse_seek(11'h123, 4'h3);
        repeat (8) @(negedge i_sys_clk);
        chk("sense byte", 8'h24, o_sense_byte1);
        chk("track high", 8'h01, {5'h0, o_track[10:8]});
        chk("track low", 8'h23, o_track[7:0]);
        $display("test reset_sense done");
    endtask
    task automatic test_protect();
        int n;
        do_reset();
        i_protect = 1'b1;
        // The fill phase ends once eight bytes arrive or the channel signals done, so the channel must run
        run = 1'b1;
        pulse_seek(11'h123, 4'h3);
        repeat (6) @(negedge i_sys_clk);
        pulse_start();
        for (n = 0; n < 3000 && o_busy !== 1'b0; n++) @(negedge i_sys_clk);
        chk("violation", 8'h01, {7'h0, o_protect_violation});
        i_protect = 1'b0;
        run = 1'b0;
        $display("test protect done");
    endtask
    // Decodes the stream cell by cell: first half must be the inverse of the second
    task automatic test_write(input disc_write_pkg::path_width_e pw);
        int n;
        int k;
        int b;
        logic a;
        logic [7:0] got;
        logic [7:0] exp;
        do_reset();
        i_path_width = pw;
        i_cur_sector = 4'h3;
        pulse_seek(11'h123, 4'h3);
        run = 1'b1;
        repeat (6) @(negedge i_sys_clk);
        pulse_start();
        for (n = 0; n < 8000 && o_ser_en !== 1'b1; n++) @(negedge i_sys_clk);
        for (k = 0; k < 18; k++) begin
            for (b = 7; b >= 0; b--) begin
                repeat (3) @(negedge i_sys_clk);
                a = o_ser_data;
                repeat (8) @(negedge i_sys_clk);
                got[b] = o_ser_data;
                chk("cell halves", 8'h01, {7'h0, a ^ got[b]});
                repeat (5) @(negedge i_sys_clk);
            end
            exp = (k < 7) ? 8'h55 : (k == 7) ? 8'h5c : (k < 16) ? 8'(8'h08 + k) : 8'h00;
            chk("serial byte", exp, got);
        end
        run = 1'b0;
        $display("test write done");
    endtask

    initial begin
        test_reset_sense();
        test_protect();
        test_write(disc_write_pkg::PATH_32);
        test_write(disc_write_pkg::PATH_16);
        test_write(disc_write_pkg::PATH_8);
        finish_test();
    end
    // Three short write runs of eighteen bytes each stay well under this span
    initial begin
        #(40000 * 20);
        n_mismatch++;
        finish_test();
    end
endmodule // disc_write_order_datapath_test

`default_nettype wire

// [tb/io_channel_model.sv]
`timescale 1ns/1ps
`default_nettype none

module io_channel_model (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_run,
    input  wire logic                        i_chan_req,
    input  wire disc_write_pkg::path_width_e i_path_width,
    output var disc_write_pkg::chan_word_s   o_chan,
    output logic                             o_done
);
    logic [7:0] sent;
    logic [7:0] b0;
    logic [2:0] nb;
    logic       told;
    assign nb = (i_path_width == disc_write_pkg::PATH_8)  ? 3'd1 :
                (i_path_width == disc_write_pkg::PATH_16) ? 3'd2 : 3'd4;
    assign b0 = 8'h10 + sent;
    initial begin
        sent   = 8'h00;
        told   = 1'b0;
        o_done = 1'b0;
        o_chan = '0;
    end
    // A word counts only on the edge where request and valid meet
    always @(posedge i_sys_clk) begin
        if (!i_run) sent <= 8'h00;
        else if (i_chan_req && o_chan.valid) sent <= sent + 8'(nb);
    end
    // Only eight bytes are offered so the device must zero fill behind them
    always @(negedge i_sys_clk) begin
        o_done       <= 1'b0;
        o_chan.valid <= i_run && sent < 8'd8;
        if (i_run && sent < 8'd8) begin
            o_chan.data <= {b0, b0 + 8'h01, b0 + 8'h02, b0 + 8'h03} >> (8 * (3'd4 - nb));
        end else begin
            o_chan.data <= ~o_chan.data;
        end
        if (!i_run) told <= 1'b0;
        else if (sent >= 8'd8 && !told) begin
            o_done <= 1'b1;
            told   <= 1'b1;
        end
    end
endmodule // io_channel_model

`default_nettype wire
